// [bench/pmws_core_model.sv]
// Processor core and interrupt-controller model facing the sequencer
`timescale 1ns/1ps
module pmws_core_model
   import pmws_pkg::*;
(
   input  wire logic        mclk,
   input  wire logic        sys_reset_n,
   input  wire logic        core_clk_en,
   input  wire logic [2:0]  want_mode,
   input  wire logic [31:0] en_mask,
   output logic      [2:0]  mode_req,
   output logic      [31:0] irq_mask
);
   logic [2:0] want_q;

   // Wish is latched on the rising edge so the falling-edge drive never races the bench
   always @(posedge mclk)
      want_q <= want_mode;

   // A halted core issues nothing; after a wake it stays idle until asked again
   always @(negedge mclk)
   begin
      mode_req <= (sys_reset_n && core_clk_en) ? want_q : PMWS_REQ_NONE;
      irq_mask <= en_mask;
   end
endmodule

// [bench/tb_power_mode_wake_sequencer.sv]
// Self-checking testbench for the power-mode and wake-up sequencer
`timescale 1ns/1ps
module tb_power_mode_wake_sequencer;
   import pmws_pkg::*;
   // Short counts keep the run brief; expectations derive from these
   localparam int XT = 16;
   localparam int IU = 10;
   localparam int FU = 20;
   logic        mclk, rst_n, ext_reset_n, osc_ok, flash_init_done, use_main_osc;
   logic        rtc_dpd_req, rtc_alarm, flash_req;
   logic [2:0]  want_mode, mode_req;
   logic [31:0] en_mask, irq_mask, irq_in;
   logic [7:0]  per_clk_en, per_clk_gate;
   logic        sys_reset_n, core_clk_en, clk_sel_irc, main_osc_en, irc_out_en, irc_pwr;
   logic        pll_on, div_clear, flash_pwr, flash_ready, flash_stall, rtc_only;
   int          bad_count = 0, n_compared = 0, cyc = 0, n = 0;

   pmws_sequencer #(.NIRQ(32), .NPER(8), .XTAL_CYC(XT), .IRC_UP_CYC(IU), .FLASH_UP_CYC(FU)) dut_u (
      .mclk(mclk), .rst_n(rst_n), .ext_reset_n(ext_reset_n), .osc_ok(osc_ok),
      .flash_init_done(flash_init_done), .mode_req(mode_req), .use_main_osc(use_main_osc),
      .rtc_dpd_req(rtc_dpd_req), .rtc_alarm(rtc_alarm), .irq_mask(irq_mask), .irq_in(irq_in),
      .per_clk_en(per_clk_en), .flash_req(flash_req), .sys_reset_n(sys_reset_n),
      .core_clk_en(core_clk_en), .per_clk_gate(per_clk_gate), .clk_sel_irc(clk_sel_irc),
      .main_osc_en(main_osc_en), .irc_out_en(irc_out_en), .irc_pwr(irc_pwr), .pll_on(pll_on),
      .div_clear(div_clear), .flash_pwr(flash_pwr), .flash_ready(flash_ready),
      .flash_stall(flash_stall), .rtc_only(rtc_only));

   pmws_core_model core_u (.mclk(mclk), .sys_reset_n(sys_reset_n), .core_clk_en(core_clk_en),
      .want_mode(want_mode), .en_mask(en_mask), .mode_req(mode_req), .irq_mask(irq_mask));

   // Clock, 20 ns period
   initial
   begin
      mclk = 1'b0;
      forever #10 mclk = ~mclk;
   end

   // Hang guard: far above the few hundred cycles the scenarios need
   always @(posedge mclk)
   begin
      cyc++;
      if (cyc == 20000)
      begin
         bad_count++;
         final_report();
      end
   end

   task automatic final_report();
      if (bad_count == 0 && n_compared > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask

   task automatic chk_val(input logic [31:0] got, input logic [31:0] exp);
      n_compared++;
      if (got !== exp)
      begin
         bad_count++;
         $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   // Cycle count must fall inside a window; the window's low end is what a broken count misses
   task automatic chk_rng(input int got, input int lo, input int hi);
      n_compared++;
      if (got < lo || got > hi)
      begin
         bad_count++;
         $display("ERROR t=%0t got=%h exp=%h..%h", $time, got, lo, hi);
      end
   endtask

   // Wait, bounded, on falling edges for an output to reach a level
   task automatic wait_for(input int sel, input logic lvl, output int cnt);
      logic v;
      cnt = 0;
      do
      begin
         @(negedge mclk);
         cnt++;
         case (sel)
            0: v = core_clk_en;
            1: v = sys_reset_n;
            2: v = flash_ready;
            default: v = rtc_only;
         endcase
      end while (v !== lvl && cnt < 300);
   endtask

   // Ask the core model for a mode and wait for the core clock to stop
   task automatic enter(input logic [2:0] m);
      want_mode = m;
      wait_for(0, 1'b0, n);
      want_mode = PMWS_REQ_NONE;
   endtask

   task automatic t_boot();
      chk_val(clk_sel_irc, 1'b1);
      repeat (30) @(negedge mclk);
      chk_val(sys_reset_n, 1'b0);
      flash_init_done = 1'b1;
      wait_for(1, 1'b1, n);
      chk_rng(n, 1, 4);
      chk_val(core_clk_en, 1'b1);
   endtask

   task automatic t_sleep();
      logic osc;
      osc = main_osc_en;
      en_mask = 32'h0;
      enter(PMWS_REQ_SLEEP);
      chk_val(per_clk_gate, 8'h5a);
      chk_val({main_osc_en, irc_out_en, div_clear}, {osc, 2'b10});
      irq_in = 32'h0000_0100;
      wait_for(0, 1'b1, n);
      chk_rng(n, 1, 8);
      irq_in = 32'h0;
      chk_val(per_clk_gate, 8'h5a);
   endtask

   task automatic t_deep(input logic main);
      use_main_osc = main;
      en_mask = 32'h0000_0008;
      repeat (4) @(negedge mclk);
      enter(PMWS_REQ_DSLP);
      chk_val({div_clear, pll_on, irc_out_en, irc_pwr, flash_pwr}, 5'b10011);
      chk_val({main_osc_en, per_clk_gate}, 9'h0);
      @(negedge mclk);
      chk_val(div_clear, 1'b0);
      irq_in = 32'h0000_0020;
      repeat (20) @(negedge mclk);
      chk_val(core_clk_en, 1'b0);
      irq_in = 32'h0000_0028;
      wait_for(0, 1'b1, n);
      if (main)
         chk_rng(n, XT + 3, XT + 6);
      else
         chk_rng(n, 4 + 3, 4 + 6);
      chk_val(pll_on, 1'b0);
      irq_in = 32'h0;
      use_main_osc = 1'b0;
   endtask

   task automatic t_pdown();
      en_mask = 32'h8000_0000;
      enter(PMWS_REQ_PDOWN);
      chk_val({irc_pwr, flash_pwr, flash_ready, irc_out_en, pll_on}, 5'b0);
      irq_in = 32'h8000_0000;
      flash_req = 1'b1;
      wait_for(0, 1'b1, n);
      chk_rng(n, IU + 4, IU + 10);
      chk_val({clk_sel_irc, flash_stall}, 2'b11);
      wait_for(2, 1'b1, n);
      chk_rng(n + IU + 4, IU + FU, IU + FU + 10);
      @(negedge mclk);
      chk_val(flash_stall, 1'b0);
      irq_in = 32'h0;
      flash_req = 1'b0;
   endtask

   task automatic t_dpd();
      en_mask = 32'h1;
      rtc_dpd_req = 1'b1;
      wait_for(3, 1'b1, n);
      rtc_dpd_req = 1'b0;
      chk_rng(n, 1, 3);
      chk_val({core_clk_en, flash_pwr, irc_pwr, main_osc_en}, 4'h0);
      irq_in = 32'h1;
      repeat (20) @(negedge mclk);
      chk_val({rtc_only, core_clk_en}, 2'b10);
      irq_in = 32'h0;
      rtc_alarm = 1'b1;
      wait_for(1, 1'b0, n);
      chk_rng(n, 1, 6);
      rtc_alarm = 1'b0;
      wait_for(1, 1'b1, n);
      chk_rng(n, 16, 30);
   endtask

   // Pin reset out of deep power-down, then a late oscillator holds the boot count
   task automatic t_ext_reset();
      rtc_dpd_req = 1'b1;
      wait_for(3, 1'b1, n);
      rtc_dpd_req = 1'b0;
      ext_reset_n = 1'b0;
      wait_for(1, 1'b0, n);
      chk_rng(n, 1, 5);
      chk_val({clk_sel_irc, core_clk_en}, 2'b10);
      chk_val({rtc_only, flash_pwr, irc_pwr}, 3'b011);
      osc_ok = 1'b0;
      repeat (4) @(negedge mclk);
      ext_reset_n = 1'b1;
      repeat (30) @(negedge mclk);
      chk_val(sys_reset_n, 1'b0);
      osc_ok = 1'b1;
      wait_for(1, 1'b1, n);
      chk_rng(n, 16, 30);
   endtask

   // Main sequence: all inputs valued at time zero, reset held two cycles
   initial
   begin
      rst_n = 1'b0;
      ext_reset_n = 1'b1;
      osc_ok = 1'b1;
      flash_init_done = 1'b0;
      use_main_osc = 1'b0;
      {rtc_dpd_req, rtc_alarm, flash_req} = 3'b000;
      want_mode = PMWS_REQ_NONE;
      en_mask = 32'h0;
      irq_in = 32'h0;
      per_clk_en = 8'h5a;
      repeat (2) @(negedge mclk);
      rst_n = 1'b1;
      t_boot();
      t_sleep();
      t_deep(1'b0);
      t_deep(1'b1);
      t_pdown();
      t_dpd();
      t_ext_reset();
      final_report();
   end
endmodule

// [design/pmws_params.svh]
// Constants for the power-mode and wake-up sequencer
`ifndef PMWS_PARAMS_SVH
`define PMWS_PARAMS_SVH
`define PMWS_CLK_MHZ          50
`define PMWS_IRC_MHZ          4
`define PMWS_IRC_START_US     60
`define PMWS_FLASH_START_US   100
`define PMWS_IRC_RESUME_CYC   4
`define PMWS_XTAL_RESUME_CYC  4096
`define PMWS_RESET_CYC        16
`define PMWS_IRC_START_CNT    ((`PMWS_IRC_START_US * `PMWS_CLK_MHZ))
`define PMWS_FLASH_START_CNT  ((`PMWS_FLASH_START_US * `PMWS_CLK_MHZ))
`define PMWS_IRC_DIV          ((`PMWS_CLK_MHZ + `PMWS_IRC_MHZ - 1) / `PMWS_IRC_MHZ)
`endif

// [design/pmws_pkg.sv]
// Types shared by the power-mode and wake-up sequencer
package pmws_pkg;
   typedef enum logic [2:0]
   {
      PMWS_REQ_NONE  = 3'h0,
      PMWS_REQ_SLEEP = 3'h1,
      PMWS_REQ_DSLP  = 3'h2,
      PMWS_REQ_PDOWN = 3'h3
   } pmws_req_t;

   typedef enum logic [7:0]
   {
      PMWS_ST_RESET = 8'h01,
      PMWS_ST_RUN   = 8'h02,
      PMWS_ST_SLEEP = 8'h04,
      PMWS_ST_DSLP  = 8'h08,
      PMWS_ST_PDOWN = 8'h10,
      PMWS_ST_DPD   = 8'h20,
      PMWS_ST_IRCUP = 8'h40,
      PMWS_ST_RESUM = 8'h80
   } pmws_state_t;
endpackage

// [design/pmws_sequencer.sv]
// Power-mode and wake-up sequencer top module
`timescale 1ns/1ps
`include "pmws_params.svh"
// Overview of operation
// - Boot and power-down wake use RC oscillator
// - Wake timer guards crystal only on deep-sleep wake
// - Four reduced-power states supported
// - Sleep gates only the core clock
// - Sleep keeps peripherals; interrupt or reset wakes
// - Deep-sleep stops oscillator, gates all clocks
// - Deep-sleep gates RC output, RTC keeps running
// - Deep-sleep kills PLL, clears CPU/USB dividers
// - Deep-sleep ends on reset or clockless interrupt
// - Flash stays powered in deep-sleep
// - Resume after 4 or 4096 cycles
// - Power-down also unpowers RC and flash
// - Power-down wake: 60 us, then 4 cycles
// - Flash counter covers 100 us start-up
// - Deep power-down only via RTC, keeps RTC
// - Deep power-down exits on reset or alarm
// - Interrupt controller mask captured on entry
// - Masked interrupt wakes core without polling
// - Per-peripheral clock gate, taken from per_clk_en
// - Any reset restarts wake timer sequence
module pmws_sequencer
   import pmws_pkg::*;
#(
   parameter int NIRQ         = 32,
   parameter int NPER         = 8,
   parameter int XTAL_CYC     = `PMWS_XTAL_RESUME_CYC,
   parameter int IRC_UP_CYC   = `PMWS_IRC_START_CNT,
   parameter int FLASH_UP_CYC = `PMWS_FLASH_START_CNT
)
(
   input  wire logic            mclk,
   input  wire logic            rst_n,
   input  wire logic            ext_reset_n,
   input  wire logic            osc_ok,
   input  wire logic            flash_init_done,
   input  wire logic [2:0]      mode_req,
   input  wire logic            use_main_osc,
   input  wire logic            rtc_dpd_req,
   input  wire logic            rtc_alarm,
   input  wire logic [NIRQ-1:0] irq_mask,
   input  wire logic [NIRQ-1:0] irq_in,
   input  wire logic [NPER-1:0] per_clk_en,
   input  wire logic            flash_req,
   output logic                 sys_reset_n,
   output logic                 core_clk_en,
   output logic [NPER-1:0]      per_clk_gate,
   output logic                 clk_sel_irc,
   output logic                 main_osc_en,
   output logic                 irc_out_en,
   output logic                 irc_pwr,
   output logic                 pll_on,
   output logic                 div_clear,
   output logic                 flash_pwr,
   output logic                 flash_ready,
   output logic                 flash_stall,
   output logic                 rtc_only
);
   localparam int CW = 20;

   typedef struct packed
   {
      pmws_state_t     st;
      logic [CW-1:0]   cnt;
      logic [CW-1:0]   fcnt;
      logic            src_main;
      logic [1:0]      ext_s;
      logic [1:0]      osc_s;
      logic [1:0]      alm_s;
      logic [1:0]      dpd_s;
      logic [NIRQ-1:0] irq_s1;
      logic [NIRQ-1:0] irq_s2;
      logic            sys_reset_n;
      logic            core_clk_en;
      logic [NPER-1:0] per_clk_gate;
      logic            clk_sel_irc;
      logic            main_osc_en;
      logic            irc_out_en;
      logic            irc_pwr;
      logic            pll_on;
      logic            div_clear;
      logic            flash_pwr;
      logic            flash_ready;
      logic            flash_stall;
      logic            rtc_only;
   } pmws_top_t;

   pmws_top_t r;
   pmws_top_t next_r;
   logic      wake;
   logic      capture;
   logic      release_mask;

   function automatic logic [CW-1:0] to_cw(input int v);
      to_cw = v[CW-1:0];
   endfunction

   // Mask is captured on any deep entry and freed once back in run
   assign capture      = (r.st == PMWS_ST_RUN) && (mode_req == PMWS_REQ_DSLP || mode_req == PMWS_REQ_PDOWN
                         || r.dpd_s[1]);
   assign release_mask = (r.st == PMWS_ST_RUN);

   pmws_wake_helper #(
      .NIRQ (NIRQ)
   ) u_wake (
      .mclk         (mclk),
      .rst_n        (rst_n),
      .capture      (capture),
      .release_mask (release_mask),
      .mask_in      (irq_mask),
      .irq_sync     (r.irq_s2),
      .wake         (wake)
   );

   // Sequencer: mode decode, clock/power controls and wake counters
   always_comb
   begin
      next_r = r;
      next_r.ext_s  = {r.ext_s[0], ext_reset_n};
      next_r.osc_s  = {r.osc_s[0], osc_ok};
      next_r.alm_s  = {r.alm_s[0], rtc_alarm};
      next_r.dpd_s  = {r.dpd_s[0], rtc_dpd_req};
      next_r.irq_s1 = irq_in;
      next_r.irq_s2 = r.irq_s1;
      next_r.div_clear = 1'b0;
      if (r.fcnt != '0)
         next_r.fcnt = r.fcnt - to_cw(1);
      case (r.st)
         PMWS_ST_RESET:
         begin
            // Held until pin released, oscillator up, count done, flash ready
            if (!r.ext_s[1] || !r.osc_s[1])
               next_r.cnt = to_cw(`PMWS_RESET_CYC);
            else if (r.cnt != '0)
               next_r.cnt = r.cnt - to_cw(1);
            else if (flash_init_done)
            begin
               next_r.st          = PMWS_ST_RUN;
               next_r.sys_reset_n = 1'b1;
               next_r.core_clk_en = 1'b1;
            end
         end
         PMWS_ST_RUN:
         begin
            next_r.per_clk_gate = per_clk_en;
            next_r.src_main     = use_main_osc;
            next_r.clk_sel_irc  = !use_main_osc;
            next_r.main_osc_en  = use_main_osc;
            next_r.pll_on       = 1'b1;
            if (r.dpd_s[1])
            begin
               next_r.st           = PMWS_ST_DPD;
               next_r.rtc_only     = 1'b1;
               next_r.core_clk_en  = 1'b0;
               next_r.per_clk_gate = '0;
               next_r.main_osc_en  = 1'b0;
               next_r.irc_out_en   = 1'b0;
               next_r.irc_pwr      = 1'b0;
               next_r.pll_on       = 1'b0;
               next_r.flash_pwr    = 1'b0;
               next_r.flash_ready  = 1'b0;
            end
            else if (mode_req == PMWS_REQ_SLEEP)
            begin
               next_r.st          = PMWS_ST_SLEEP;
               next_r.core_clk_en = 1'b0;
            end
            else if (mode_req == PMWS_REQ_DSLP || mode_req == PMWS_REQ_PDOWN)
            begin
               next_r.st           = (mode_req == PMWS_REQ_DSLP) ? PMWS_ST_DSLP : PMWS_ST_PDOWN;
               next_r.core_clk_en  = 1'b0;
               next_r.per_clk_gate = '0;
               next_r.main_osc_en  = 1'b0;
               next_r.irc_out_en   = 1'b0;
               next_r.pll_on       = 1'b0;
               next_r.div_clear    = 1'b1;
               next_r.irc_pwr      = (mode_req == PMWS_REQ_DSLP);
               next_r.flash_pwr    = (mode_req == PMWS_REQ_DSLP);
               next_r.flash_ready  = (mode_req == PMWS_REQ_DSLP);
            end
         end
         PMWS_ST_SLEEP:
         begin
            // Peripheral clocks keep running so they can raise the wake
            if (|r.irq_s2)
            begin
               next_r.st          = PMWS_ST_RUN;
               next_r.core_clk_en = 1'b1;
            end
         end
         PMWS_ST_DSLP:
         begin
            if (wake)
            begin
               next_r.st          = PMWS_ST_RESUM;
               next_r.irc_out_en  = 1'b1;
               next_r.clk_sel_irc = 1'b1;
               next_r.main_osc_en = r.src_main;
               next_r.cnt = r.src_main ? to_cw(XTAL_CYC - 1) : to_cw(`PMWS_IRC_RESUME_CYC - 1);
            end
         end
         PMWS_ST_PDOWN:
         begin
            if (wake)
            begin
               next_r.st          = PMWS_ST_IRCUP;
               next_r.irc_pwr     = 1'b1;
               next_r.flash_pwr   = 1'b1;
               next_r.clk_sel_irc = 1'b1;
               next_r.cnt         = to_cw(IRC_UP_CYC - 1);
            end
         end
         PMWS_ST_IRCUP:
         begin
            if (r.cnt != '0)
               next_r.cnt = r.cnt - to_cw(1);
            else
            begin
               next_r.st         = PMWS_ST_RESUM;
               next_r.irc_out_en = 1'b1;
               next_r.cnt        = to_cw(`PMWS_IRC_RESUME_CYC - 1);
               next_r.fcnt       = to_cw(FLASH_UP_CYC);
            end
         end
         PMWS_ST_RESUM:
         begin
            // Crystal not used by code until count ends; PLL off on resume, turned back on by run one cycle later
            if (r.cnt != '0)
               next_r.cnt = r.cnt - to_cw(1);
            else
            begin
               next_r.st          = PMWS_ST_RUN;
               next_r.core_clk_en = 1'b1;
               next_r.pll_on      = 1'b0;
            end
         end
         PMWS_ST_DPD:
            next_r.rtc_only = 1'b1; // exits only by reset or alarm
         default:
            next_r.st = PMWS_ST_RESET;
      endcase
      // Alarm or reset pin: supplies come back too, else a pin reset from a deep mode stays unpowered
      if ((r.st == PMWS_ST_DPD && r.alm_s[1]) || (!r.ext_s[1] && r.st != PMWS_ST_RESET))
      begin
         next_r.st           = PMWS_ST_RESET;
         next_r.rtc_only     = 1'b0;
         next_r.irc_pwr      = 1'b1;
         next_r.irc_out_en   = 1'b1;
         next_r.flash_pwr    = 1'b1;
         next_r.clk_sel_irc  = 1'b1;
         next_r.main_osc_en  = 1'b0;
         next_r.pll_on       = 1'b0;
         next_r.core_clk_en  = 1'b0;
         next_r.per_clk_gate = '0;
         next_r.cnt          = to_cw(`PMWS_RESET_CYC);
         next_r.sys_reset_n  = 1'b0;
      end
      // Flash becomes usable only when the start-up counter has run out
      next_r.flash_ready = next_r.flash_pwr && (next_r.fcnt == '0) && (next_r.st != PMWS_ST_IRCUP);
      next_r.flash_stall = flash_req && !next_r.flash_ready;
   end

   // Reset lands in the RC-clocked boot state
   always_ff @(posedge mclk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         r             <= '0;
         r.st          <= PMWS_ST_RESET;
         r.cnt         <= to_cw(`PMWS_RESET_CYC);
         r.clk_sel_irc <= 1'b1;
         r.irc_out_en  <= 1'b1;
         r.irc_pwr     <= 1'b1;
         r.flash_pwr   <= 1'b1;
      end
      else
         r <= next_r;
   end

   assign sys_reset_n  = r.sys_reset_n;
   assign core_clk_en  = r.core_clk_en;
   assign per_clk_gate = r.per_clk_gate;
   assign clk_sel_irc  = r.clk_sel_irc;
   assign main_osc_en  = r.main_osc_en;
   assign irc_out_en   = r.irc_out_en;
   assign irc_pwr      = r.irc_pwr;
   assign pll_on       = r.pll_on;
   assign div_clear    = r.div_clear;
   assign flash_pwr    = r.flash_pwr;
   assign flash_ready  = r.flash_ready;
   assign flash_stall  = r.flash_stall;
   assign rtc_only     = r.rtc_only;

   AST_SLEEP_CORE_ONLY: assert property (@(posedge mclk) disable iff (!rst_n)
      (r.st == PMWS_ST_SLEEP) |-> (!core_clk_en && irc_out_en))
      else $error("Sleep gated more than the core");
   AST_DSLP_CLOCKS: assert property (@(posedge mclk) disable iff (!rst_n)
      (r.st == PMWS_ST_DSLP) |-> (!core_clk_en && per_clk_gate == '0 && !main_osc_en))
      else $error("Deep-sleep clocks not stopped");
   AST_DSLP_IRC_POWERED: assert property (@(posedge mclk) disable iff (!rst_n)
      (r.st == PMWS_ST_DSLP) |-> (irc_pwr && !irc_out_en))
      else $error("Deep-sleep RC gating wrong");
   AST_DSLP_DIV_CLEAR: assert property (@(posedge mclk) disable iff (!rst_n)
      (r.st == PMWS_ST_RUN && mode_req == PMWS_REQ_DSLP && !r.dpd_s[1] && r.ext_s[1]) |=> (div_clear && !pll_on))
      else $error("Dividers not cleared on deep-sleep");
   AST_DSLP_FLASH_ON: assert property (@(posedge mclk) disable iff (!rst_n)
      (r.st == PMWS_ST_DSLP) |-> flash_pwr)
      else $error("Flash unpowered in deep-sleep");
   AST_PDOWN_OFF: assert property (@(posedge mclk) disable iff (!rst_n)
      (r.st == PMWS_ST_PDOWN) |-> (!irc_pwr && !flash_pwr))
      else $error("Power-down left RC or flash on");
   AST_IRC_RESUME: assert property (@(posedge mclk) disable iff (!rst_n)
      (r.st == PMWS_ST_DSLP && wake && !r.src_main && r.ext_s[1]) |=> ##4 core_clk_en)
      else $error("RC resume not four cycles");
   AST_FLASH_STALL: assert property (@(posedge mclk) disable iff (!rst_n)
      (flash_req && r.fcnt > to_cw(1)) |=> (flash_stall && !flash_ready))
      else $error("Flash request not stalled");
   AST_DPD_HOLD: assert property (@(posedge mclk) disable iff (!rst_n)
      (r.st == PMWS_ST_DPD && !r.alm_s[1] && r.ext_s[1]) |=> (r.st == PMWS_ST_DPD))
      else $error("Left deep power-down without cause");

   COV_SLEEP: cover property (@(posedge mclk) disable iff (!rst_n) r.st == PMWS_ST_SLEEP ##1 r.st == PMWS_ST_RUN);
   COV_DSLP: cover property (@(posedge mclk) disable iff (!rst_n) r.st == PMWS_ST_DSLP ##1 r.st == PMWS_ST_RESUM);
   COV_PDOWN: cover property (@(posedge mclk) disable iff (!rst_n) r.st == PMWS_ST_IRCUP ##1 r.st == PMWS_ST_RESUM);
   COV_DPD: cover property (@(posedge mclk) disable iff (!rst_n) r.st == PMWS_ST_DPD ##1 r.st == PMWS_ST_RESET);
endmodule

// [design/pmws_wake_helper.sv]
// Wake-up interrupt helper: captures the mask and detects wake without a clock
`timescale 1ns/1ps
`include "pmws_params.svh"
module pmws_wake_helper
   import pmws_pkg::*;
#(
   parameter int NIRQ = 32
)
(
   input  wire logic            mclk,
   input  wire logic            rst_n,
   input  wire logic            capture,
   input  wire logic            release_mask,
   input  wire logic [NIRQ-1:0] mask_in,
   input  wire logic [NIRQ-1:0] irq_sync,
   output logic                 wake
);
   typedef struct packed
   {
      logic [NIRQ-1:0] mask;
      logic            wake;
   } pmws_wh_t;

   pmws_wh_t r;
   pmws_wh_t next_r;

   // Mask is held only while clocks are stopped; wake is a level, no polling
   always_comb
   begin
      next_r = r;
      if (capture)
         next_r.mask = mask_in;
      else if (release_mask)
         next_r.mask = '0;
      next_r.wake = |(next_r.mask & irq_sync);
   end

   always_ff @(posedge mclk or negedge rst_n)
   begin
      if (!rst_n)
         r <= '0;
      else
         r <= next_r;
   end

   assign wake = r.wake;

   AST_WAKE_FROM_MASK: assert property (@(posedge mclk) disable iff (!rst_n)
      (!capture && !release_mask && |(r.mask & irq_sync)) |=> wake)
      else $error("Masked interrupt did not wake");
endmodule
